// >>> logic/bde_core.sv
// Operation
// - low request line at reset release enables debug until next reset
// - line resampled each reset release; high leaves debug disabled
// - enabled breakpoint enters debug; else breakpoint exception vector 0c
// - double bus fault enters debug if enabled, else halts
// - entry opcode enters debug if enabled, else illegal trap
// - breakpoint instruction never enters debug
// - no breakpoint acknowledge bus cycle on debug entry
// - peripheral breakpoints share the line and are treated identically
// - entry suspends execution and raises halted indicator first
// - after halted, serial hardware enabled, waits for command
// - scratch register gets entry source code
// - last-instruction pointer odd only for fault straight from reset
// - command is 16-bit operation word plus extension words
// - execute on last word (here on the operation word; extension words are only counted); results shift out during next command
// - fault address captured on bus error, held until next cycle
// - return pointer gives resume address; odd raises address error
// - last-instruction pointer holds last executed instruction start
// - released-write breakpoint acknowledged at end of completing instruction
// - in debug, no parallel fetches; serial only
// - halted indicator drops before first resume prefetch
// - serial transfer is 17 bits: 16 data plus status
`timescale 1ns/1ps
module bde_core (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic breakpoint_request_line_line_n,
	input wire logic serial_in,
	input wire logic instr_end,
	input wire logic [15:0] instr_opcode,
	input wire logic [31:0] instr_addr,
	input wire logic released_write_busy,
	input wire logic bus_cycle_done,
	input wire bde_pkg::bde_fault_t fault,
	input wire logic cmd_done,
	input wire logic [3:0] cmd_ext_words,
	input wire logic [16:0] cmd_result,
	input wire logic resume_req,
	input wire logic [31:0] return_ptr_wr,
	input wire logic return_ptr_we,
	output logic halted,
	output logic serial_out,
	output logic fetch_enable,
	output logic exc_valid,
	output logic [7:0] exc_vector,
	output logic exc_illegal,
	output logic exc_addr_error,
	output logic cpu_halt,
	output logic breakpoint_request_line_ack_cycle,
	output logic prefetch_start,
	output logic [31:0] prefetch_addr,
	output logic [31:0] scratch_reg,
	output logic [31:0] fault_address_reg,
	output logic [31:0] return_fetch_pointer_reg,
	output logic [31:0] last_instruction_pointer_reg,
	output bde_pkg::bde_word_t cmd_word,
	output logic cmd_exec
);
	bde_pkg::bde_state_t state_reg;
	bde_pkg::bde_state_t state_next;
	logic breakpoint_request_line_s;
	logic sdin_s;
	logic rst_d_reg;
	logic [1:0] low_cnt_reg;
	logic debug_en_reg;
	logic breakpoint_request_line_pend_reg;
	logic first_instr_reg;
	logic [3:0] words_left_reg;
	logic serial_en_reg;
	bde_pkg::bde_word_t rx_word;
	logic sdout;

	// ----------------------------------------
	// request line synchroniser
	// ----------------------------------------
	// two-stage sync
	bde_sync u_breakpoint_request_line_sync (
		.ref_clk(ref_clk),
		.rst_n(1'b1),
		.async_in(breakpoint_request_line_line_n),
		.sync_out(breakpoint_request_line_s)
	);

	// data takes the same two stages so it stays aligned with its clock
	bde_sync u_sdin_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.async_in(serial_in),
		.sync_out(sdin_s)
	);

	// ----------------------------------------
	// entry decode
	// ----------------------------------------
	wire in_run = (state_reg == bde_pkg::BDE_RUN);
	wire breakpoint_request_line_req = ~breakpoint_request_line_s | breakpoint_request_line_pend_reg;
	wire breakpoint_request_line_acc = breakpoint_request_line_req && instr_end && !released_write_busy && in_run;
	wire opc_hit = instr_end && in_run && (instr_opcode == bde_pkg::OPC_DEBUG_ENTRY);
	wire dbf_hit = fault.double_fault && in_run;
	wire enter_dbg = debug_en_reg && (breakpoint_request_line_acc || opc_hit || dbf_hit);
	wire rst_rise = rst_n && !rst_d_reg;
	wire brk_ill = instr_end && in_run && !enter_dbg
		&& ((instr_opcode & bde_pkg::OPC_BREAKPOINT_REQUEST_LINE_MASK) == bde_pkg::OPC_BREAKPOINT_REQUEST_LINE_INSN);
	wire rx_last = rx_word.valid && (words_left_reg == 4'd0);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			bde_pkg::BDE_RUN: begin
				if (enter_dbg) begin
					state_next = bde_pkg::BDE_ENTER;
				end else if (dbf_hit) begin
					state_next = bde_pkg::BDE_HALT;
				end
			end
			bde_pkg::BDE_ENTER: state_next = bde_pkg::BDE_DEBUG;
			bde_pkg::BDE_DEBUG: begin
				if (resume_req) begin
					state_next = bde_pkg::BDE_RUN;
				end
			end
			bde_pkg::BDE_HALT: state_next = bde_pkg::BDE_HALT;
			default: state_next = bde_pkg::BDE_RUN;
		endcase
	end

	// ----------------------------------------
	// enable latch at reset release
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		rst_d_reg <= rst_n;
		if (!rst_n) begin
			// count low clocks while reset held
			low_cnt_reg <= breakpoint_request_line_s ? 2'd0 : (low_cnt_reg == 2'd3 ? 2'd3 : low_cnt_reg + 2'd1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			debug_en_reg <= 1'b0;
		end else if (rst_rise) begin
			debug_en_reg <= !breakpoint_request_line_s && (low_cnt_reg >= 2'(bde_pkg::BREAKPOINT_REQUEST_LINE_LOW_MIN_CYC - 1));
		end
	end

	// ----------------------------------------
	// state and exceptions
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg <= bde_pkg::BDE_RUN;
			breakpoint_request_line_pend_reg <= 1'b0;
			halted <= 1'b0;
			fetch_enable <= 1'b0;
			exc_valid <= 1'b0;
			exc_vector <= 8'h00;
			exc_illegal <= 1'b0;
			exc_addr_error <= 1'b0;
			cpu_halt <= 1'b0;
			breakpoint_request_line_ack_cycle <= 1'b0;
			prefetch_start <= 1'b0;
			prefetch_addr <= bde_pkg::PTR_RESET;
			serial_en_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			breakpoint_request_line_pend_reg <= breakpoint_request_line_acc ? 1'b0 : (breakpoint_request_line_pend_reg | (~breakpoint_request_line_s & released_write_busy));
			halted <= (state_next == bde_pkg::BDE_ENTER) || (state_next == bde_pkg::BDE_DEBUG);
			serial_en_reg <= halted && (state_reg == bde_pkg::BDE_DEBUG) && !resume_req;
			// no fetch in debug; halted drops before prefetch
			fetch_enable <= (state_reg == bde_pkg::BDE_RUN) && !enter_dbg && !dbf_hit;
			prefetch_start <= (state_reg == bde_pkg::BDE_DEBUG) && resume_req;
			if ((state_reg == bde_pkg::BDE_DEBUG) && resume_req) begin
				prefetch_addr <= return_fetch_pointer_reg;
			end
			exc_addr_error <= prefetch_start && prefetch_addr[0];
			exc_valid <= (!debug_en_reg && (breakpoint_request_line_acc || opc_hit)) || brk_ill;
			exc_vector <= (!debug_en_reg && breakpoint_request_line_acc) ? bde_pkg::VEC_BREAKPOINT : 8'h00;
			exc_illegal <= (!debug_en_reg && opc_hit && !breakpoint_request_line_acc) || brk_ill;
			// ack cycle only outside debug entry
			breakpoint_request_line_ack_cycle <= !debug_en_reg && breakpoint_request_line_acc;
			cpu_halt <= cpu_halt | (!debug_en_reg && dbf_hit);
		end
	end

	// ----------------------------------------
	// context registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			scratch_reg <= 32'h00000000;
			fault_address_reg <= bde_pkg::PTR_RESET;
			return_fetch_pointer_reg <= bde_pkg::PTR_RESET;
			last_instruction_pointer_reg <= bde_pkg::PTR_RESET;
			first_instr_reg <= 1'b1;
		end else begin
			if (enter_dbg) begin
				if (dbf_hit) begin
					scratch_reg <= {fault.status_word, bde_pkg::SRC_DBF_LO};
				end else if (breakpoint_request_line_acc) begin
					scratch_reg <= {bde_pkg::SRC_HI_ZERO, bde_pkg::SRC_HW_LO};
				end else begin
					scratch_reg <= {bde_pkg::SRC_HI_ZERO, bde_pkg::SRC_OPC_LO};
				end
			end
			// capture faulting or last cycle address
			if (fault.bus_error || fault.double_fault || bus_cycle_done) begin
				fault_address_reg <= fault.address;
			end
			if (instr_end && in_run) begin
				first_instr_reg <= 1'b0;
				// first word of last instruction, kept even
				last_instruction_pointer_reg <= {instr_addr[31:1], 1'b0};
			end else if (enter_dbg && dbf_hit && first_instr_reg) begin
				// odd marker only for fault out of reset
				last_instruction_pointer_reg <= bde_pkg::PTR_RESET_FAULT;
			end
			if (enter_dbg) begin
				return_fetch_pointer_reg <= instr_addr;
			end else if (return_ptr_we && (state_reg == bde_pkg::BDE_DEBUG)) begin
				return_fetch_pointer_reg <= return_ptr_wr;
			end
		end
	end

	// ----------------------------------------
	// command sequencing
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			words_left_reg <= 4'd0;
			cmd_word <= '0;
			cmd_exec <= 1'b0;
			serial_out <= 1'b1;
		end else begin
			cmd_word <= rx_word;
			if (rx_word.valid) begin
				words_left_reg <= (words_left_reg == 4'd0) ? cmd_ext_words : words_left_reg - 4'd1;
			end
			cmd_exec <= rx_last;
			serial_out <= sdout;
		end
	end

	// 17-bit framing; results shift during next command
	bde_serial u_serial (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.enable(serial_en_reg),
		.sclk_s(breakpoint_request_line_s),
		.sdin_s(sdin_s),
		.load_valid(cmd_done),
		.load_word(cmd_result),
		.rx_word(rx_word),
		.sdout(sdout)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	halt_before_serial_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(serial_en_reg) |-> $past(halted))
		else $error("serial enabled without halted");
	entry_halted_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		enter_dbg |=> halted)
		else $error("halted not raised on entry");
	no_ack_cycle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		enter_dbg |=> !breakpoint_request_line_ack_cycle)
		else $error("ack cycle on debug entry");
	breakpoint_request_line_vector_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(breakpoint_request_line_acc && !debug_en_reg) |=> exc_valid && exc_vector == bde_pkg::VEC_BREAKPOINT)
		else $error("breakpoint exception missing");
	dbf_halt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(dbf_hit && !debug_en_reg) |=> cpu_halt)
		else $error("double fault did not halt");
	no_fetch_dbg_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		halted |-> !fetch_enable)
		else $error("fetch while in debug");
	halt_drop_first_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		prefetch_start |-> !halted)
		else $error("prefetch while halted");
	src_opcode_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(enter_dbg && opc_hit && !dbf_hit && !breakpoint_request_line_acc) |=> scratch_reg == 32'h00000001)
		else $error("wrong opcode source code");
	odd_pointer_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(last_instruction_pointer_reg[0] && !$past(last_instruction_pointer_reg[0]))
		|-> $past(enter_dbg && dbf_hit && first_instr_reg))
		else $error("odd last pointer");
	brk_insn_illegal_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		brk_ill |=> exc_illegal && !halted)
		else $error("breakpoint instruction not trapped");
	en_stable_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!rst_rise |=> $stable(debug_en_reg))
		else $error("enable changed outside reset");
endmodule : bde_core

// >>> logic/bde_pkg.sv
package bde_pkg;

	// ----------------------------------------
	// entry source codes for the scratch register, and pointer reset values
	// ----------------------------------------
	localparam logic [15:0] SRC_DBF_LO = 16'hffff;
	localparam logic [15:0] SRC_OPC_LO = 16'h0001;
	localparam logic [15:0] SRC_HW_LO = 16'h0000;
	localparam logic [15:0] SRC_HI_ZERO = 16'h0000;
	localparam logic [31:0] PTR_RESET_FAULT = 32'h00000001;
	localparam logic [31:0] PTR_RESET = 32'h00000000;

	// ----------------------------------------
	// opcodes and vectors
	// ----------------------------------------
	localparam logic [15:0] OPC_DEBUG_ENTRY = 16'h4afa;
	localparam logic [15:0] OPC_BREAKPOINT_REQUEST_LINE_INSN = 16'h4848;
	localparam logic [15:0] OPC_BREAKPOINT_REQUEST_LINE_MASK = 16'hfff8;
	localparam logic [7:0] VEC_BREAKPOINT = 8'h0c;

	// ----------------------------------------
	// serial word layout and request line low minimum
	// ----------------------------------------
	localparam int SER_BITS = 17;
	localparam int SER_STATUS_POS = 16;
	localparam logic [16:0] SER_NOT_READY = 17'h10000;
	localparam logic [16:0] SER_CMD_OK = 17'h0ffff;
	localparam int BREAKPOINT_REQUEST_LINE_LOW_MIN_CYC = 2;

	// ----------------------------------------
	// core state
	// ----------------------------------------
	typedef enum logic [3:0] {
		BDE_RUN = 4'b0001,
		BDE_ENTER = 4'b0010,
		BDE_DEBUG = 4'b0100,
		BDE_HALT = 4'b1000
	} bde_state_t;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} bde_word_t;

	typedef struct packed {
		logic bus_error;
		logic double_fault;
		logic [15:0] status_word;
		logic [31:0] address;
	} bde_fault_t;

endpackage : bde_pkg

// >>> logic/bde_serial.sv
`timescale 1ns/1ps
module bde_serial (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic sclk_s,
	input wire logic sdin_s,
	input wire logic load_valid,
	input wire logic [16:0] load_word,
	output bde_pkg::bde_word_t rx_word,
	output logic sdout
);
	logic sclk_d_reg;
	logic [16:0] in_sh_reg;
	logic [16:0] out_sh_reg;
	logic [4:0] cnt_reg;
	wire rise = sclk_s & ~sclk_d_reg & enable;
	wire last = rise && (cnt_reg == 5'd1);
	wire [16:0] in_next = {in_sh_reg[15:0], sdin_s};

	always_ff @(posedge ref_clk) begin
		if (!rst_n || !enable) begin
			sclk_d_reg <= 1'b1;
			in_sh_reg <= 17'h00000;
			out_sh_reg <= bde_pkg::SER_NOT_READY;
			cnt_reg <= 5'(bde_pkg::SER_BITS);
			rx_word <= '0;
			sdout <= 1'b1;
		end else begin
			sclk_d_reg <= sclk_s;
			rx_word.valid <= last;
			// 17-bit word framing
			if (rise) begin
				in_sh_reg <= in_next;
				cnt_reg <= last ? 5'(bde_pkg::SER_BITS) : cnt_reg - 5'd1;
			end
			if (last) begin
				rx_word.data <= in_next[15:0];
			end
			// result load has priority over not-ready reload
			if (load_valid) begin
				out_sh_reg <= load_word;
				sdout <= load_word[16];
			end else if (last) begin
				out_sh_reg <= bde_pkg::SER_NOT_READY;
				sdout <= 1'b1;
			end else if (rise) begin
				out_sh_reg <= {out_sh_reg[15:0], 1'b0};
				sdout <= out_sh_reg[15];
			end
		end
	end
endmodule : bde_serial

// >>> logic/bde_sync.sv
`timescale 1ns/1ps
module bde_sync (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_reg;

	// resets high: the line idles released
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meta_reg <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : bde_sync

// >>> testbench/bde_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// development system serial controller
// ----------------------------------------
module bde_host_model (
	output logic breakpoint_request_line_line_n,
	output logic serial_in,
	input wire logic serial_out
);
	// command coding is arbitrary here
	localparam logic [15:0] RD_SYS = 16'h2580;
	logic [16:0] rx;
	initial begin
		breakpoint_request_line_line_n = 1'b1;
		serial_in = 1'b0;
		rx = 17'h00000;
	end
	// shared request line
	// the bench keeps it low for at least two clocks before reset ends
	task automatic set_line(input logic v);
		breakpoint_request_line_line_n <= v;
	endtask : set_line
	// seventeen bit frame
	// msb first, data moves in the low phase, clock idles high after
	task automatic xfer(input logic [16:0] w);
		for (int i = 16; i >= 0; i--) begin
			breakpoint_request_line_line_n = 1'b0;
			rx[i] = serial_out;
			serial_in = w[i];
			#100;
			breakpoint_request_line_line_n = 1'b1;
			#100;
		end
		// released data line must not look like a held bit
		serial_in = ~w[0];
	endtask : xfer
	task automatic read_sys();
		xfer({1'b0, RD_SYS});
	endtask : read_sys
endmodule : bde_host_model

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	typedef struct packed {
		logic en;
		logic [1:0] kind;
		logic [15:0] opc;
		logic hlt;
		logic [31:0] scr;
		logic ill;
		logic exc;
		logic chalt;
	} bde_row_t;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic breakpoint_request_line_line_n, serial_in, serial_out;
	logic instr_end = 1'b0, bus_cycle_done = 1'b0, cmd_done = 1'b0;
	logic resume_req = 1'b0, return_ptr_we = 1'b0, rw_busy = 1'b0;
	logic [15:0] instr_opcode = 16'h0000;
	logic [31:0] instr_addr = 32'h00000000, return_ptr_wr = 32'h00000000;
	logic [16:0] cmd_result = 17'h00000;
	bde_pkg::bde_fault_t fault = '0;
	logic halted, fetch_enable, exc_valid, exc_illegal, exc_addr_error, cpu_halt;
	logic breakpoint_request_line_ack_cycle, prefetch_start, cmd_exec;
	logic [7:0] exc_vector, seen_vec;
	logic [31:0] prefetch_addr, scratch_reg, fault_address_reg;
	logic [31:0] return_fetch_pointer_reg, last_instruction_pointer_reg;
	bde_pkg::bde_word_t cmd_word;
	logic seen_ill, seen_exc, seen_ack, seen_adr, seen_exec;
	logic [15:0] cmd_data;
	int cmd_cnt, fail_count = 0, compares = 0;
	bde_row_t rows [7] = '{
		'{1'h1, 2'h0, 16'h4afa, 1'h1, 32'h00000001, 1'h0, 1'h0, 1'h0},
		'{1'h0, 2'h0, 16'h4afa, 1'h0, 32'h00000000, 1'h1, 1'h1, 1'h0},
		'{1'h1, 2'h0, 16'h4848, 1'h0, 32'h00000000, 1'h1, 1'h1, 1'h0},
		'{1'h1, 2'h1, 16'h4e71, 1'h1, 32'h00000000, 1'h0, 1'h0, 1'h0},
		'{1'h0, 2'h1, 16'h4e71, 1'h0, 32'h00000000, 1'h0, 1'h1, 1'h0},
		'{1'h1, 2'h2, 16'h0000, 1'h1, 32'h1234ffff, 1'h0, 1'h0, 1'h0},
		'{1'h0, 2'h2, 16'h0000, 1'h0, 32'h00000000, 1'h0, 1'h0, 1'h1}};
	always #12.5 ref_clk = ~ref_clk;
	// ----------------------------------------
	// design and far side
	// ----------------------------------------
	bde_host_model i_host (.breakpoint_request_line_line_n, .serial_in, .serial_out);
	bde_core i_dut (.ref_clk, .rst_n, .breakpoint_request_line_line_n, .serial_in, .instr_end, .instr_opcode,
		.instr_addr, .released_write_busy(rw_busy), .bus_cycle_done, .fault, .cmd_done,
		.cmd_ext_words(4'h0), .cmd_result, .resume_req, .return_ptr_wr, .return_ptr_we,
		.halted, .serial_out, .fetch_enable, .exc_valid, .exc_vector, .exc_illegal,
		.exc_addr_error, .cpu_halt, .breakpoint_request_line_ack_cycle, .prefetch_start, .prefetch_addr,
		.scratch_reg, .fault_address_reg, .return_fetch_pointer_reg,
		.last_instruction_pointer_reg, .cmd_word, .cmd_exec);
	// pulses are caught here so checks can come later
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			{seen_ill, seen_exc, seen_ack, seen_adr, seen_exec} <= 5'h00;
			seen_vec <= 8'h00;
			cmd_cnt <= 0;
		end else begin
			if (exc_illegal) seen_ill <= 1'b1;
			if (exc_valid) seen_exc <= 1'b1;
			if (exc_valid) seen_vec <= exc_vector;
			if (breakpoint_request_line_ack_cycle) seen_ack <= 1'b1;
			if (exc_addr_error) seen_adr <= 1'b1;
			if (cmd_exec) seen_exec <= 1'b1;
			if (cmd_word.valid) cmd_cnt <= cmd_cnt + 1;
			if (cmd_word.valid) cmd_data <= cmd_word.data;
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report
	// reset with the line held low four clocks when enabling
	task automatic entry(input bde_row_t w);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		i_host.set_line(~w.en);
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		i_host.set_line(1'b1);
		repeat (3) @(posedge ref_clk);
		if (w.kind == 2'h1) begin
			i_host.set_line(1'b0);
			repeat (3) @(posedge ref_clk);
		end
		if (w.kind == 2'h2) begin
			bus_cycle_done <= 1'b1;
			fault <= '{1'b0, 1'b1, 16'h1234, 32'h00002468};
		end else begin
			instr_end <= 1'b1;
			instr_opcode <= w.opc;
			instr_addr <= 32'h00001000;
		end
		@(posedge ref_clk);
		instr_end <= 1'b0;
		bus_cycle_done <= 1'b0;
		fault <= '0;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask : entry
	task automatic run_row(input bde_row_t w);
		entry(w);
		i_host.set_line(1'b1);
		check("halted", 32'(halted), 32'(w.hlt));
		check("scratch", scratch_reg, w.scr);
		check("illegal", 32'(seen_ill), 32'(w.ill));
		check("exception", 32'(seen_exc), 32'(w.exc));
		check("cpu halt", 32'(cpu_halt), 32'(w.chalt));
		if (w.exc) check("vector", 32'(seen_vec), w.kind == 2'h1 ? 32'h0c : 32'h00);
		check("ack cycle", 32'(seen_ack), 32'(w.kind == 2'h1 && !w.en));
		if (w.kind == 2'h2 && w.en) begin
			check("last ptr", last_instruction_pointer_reg, 32'h00000001);
			check("fault addr", fault_address_reg, 32'h00002468);
		end else begin
			check("last ptr even", 32'(last_instruction_pointer_reg[0]), 32'h0);
		end
	endtask : run_row
	// request during a released write waits for the write
	task automatic rw_case();
		@(posedge ref_clk);
		rw_busy <= 1'b1;
		entry(rows[3]);
		i_host.set_line(1'b1);
		check("rw wait", 32'(halted), 32'h0);
		@(posedge ref_clk);
		rw_busy <= 1'b0;
		instr_end <= 1'b1;
		@(posedge ref_clk);
		instr_end <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		check("rw ack", 32'(halted), 32'h1);
		check("rw source", scratch_reg, 32'h00000000);
	endtask : rw_case
	task automatic serial_case();
		entry(rows[0]);
		check("fetch off", 32'(fetch_enable), 32'h0);
		#6;
		i_host.read_sys();
		@(posedge ref_clk);
		for (int i = 0; i < 20 && cmd_cnt == 0; i++) @(posedge ref_clk);
		check("cmd word", 32'(cmd_data), 32'(i_host.RD_SYS));
		check("cmd exec", 32'(seen_exec), 32'h1);
		cmd_done <= 1'b1;
		cmd_result <= 17'h0ffff;
		@(posedge ref_clk);
		cmd_done <= 1'b0;
		// loaded reply reaches the pin one clock after the load
		@(posedge ref_clk);
		#7;
		i_host.xfer(17'h00000);
		check("reply", 32'(i_host.rx), 32'h0000ffff);
		@(posedge ref_clk);
		return_ptr_we <= 1'b1;
		return_ptr_wr <= 32'h00002001;
		@(posedge ref_clk);
		return_ptr_we <= 1'b0;
		resume_req <= 1'b1;
		@(posedge ref_clk);
		resume_req <= 1'b0;
		check("ret ptr", return_fetch_pointer_reg, 32'h00002001);
		for (int i = 0; i < 20 && prefetch_start !== 1'b1; i++) @(posedge ref_clk);
		#1;
		check("halted off", 32'(halted), 32'h0);
		check("prefetch", prefetch_addr, 32'h00002001);
		repeat (4) @(posedge ref_clk);
		check("addr error", 32'(seen_adr), 32'h1);
	endtask : serial_case
	// ----------------------------------------
	// sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int r = 0; r < 7; r++) begin
			run_row(rows[r]);
		end
		rw_case();
		serial_case();
		final_report();
	end
	initial begin
		#500000;
		fail_count++;
		final_report();
	end
endmodule : testbench
